//--- dv/test_afe_regs.sv
`timescale 1ns/1ns
module test_afe_regs;
  import afe_pkg::*;
  // ****************************************
  // Bench signals
  // ****************************************
  typedef struct packed {logic [7:0] addr; logic [31:0] wdata; logic [31:0] rexp;} afe_row_t;
  logic        core_clk, rst_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        cmp0_raw, cmp1_raw, opamp0_out, cmp0_result, cmp1_result;
  afe_ctl_t    afe_ctl, ctl_exp;
  int          bad_count, cmp_count, cyc_count;
  // Upper data bits are set on purpose: only the low byte may land
  afe_row_t rows [6] = '{
    '{AFE_OFS_REF_DAC1, 32'hFFFF_FFA5, 32'h0000_00A5},
    '{AFE_OFS_REF_DAC2, 32'h0000_005A, 32'h0000_005A},
    '{AFE_OFS_GAIN_POL, 32'hFFFF_FFFF, 32'h0000_00C7},
    '{AFE_OFS_OPAMP0_CTL, 32'hFFFF_FFFF, 32'h0000_0043},
    '{8'h14, 32'hFFFF_FFFF, 32'h0000_0000},
    '{AFE_OFS_REF_DAC2, 32'h0000_0000, 32'h0000_0000}};
  logic [5:0] gtab [8] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h38, 6'h01};
  afe_bw_t    bwtab [4] = '{AFE_BW_5K, AFE_BW_40K, AFE_BW_600K, AFE_BW_2M};

  afe_regs u_afe_regs (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cmp0_raw(cmp0_raw),
    .cmp1_raw(cmp1_raw), .opamp0_out(opamp0_out), .cmp0_result(cmp0_result),
    .cmp1_result(cmp1_result), .afe_ctl(afe_ctl));

  // ****************************************
  // Clock and hang guard
  // ****************************************
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Under two hundred cycles are needed; the ceiling leaves wide margin
  always @(posedge core_clk)
  begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == 3000)
    begin
      bad_count++;
      complete_run();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic complete_run();
    if (bad_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One single word transfer; entered just after a rising edge
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= 3'b010;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wr ? wd : ~wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, 32'(hresp));
  endtask : bus
  // Reads back every offset and the control bundle after a reset
  task automatic check_reset();
    for (int i = 0; i < 6; i++)
    begin
      bus(8'(4 * i), 1'b0, 32'h0);
      chk("reset read", 32'h0, rd);
    end
    ctl_exp = '0;
    ctl_exp.gain_ratio = AFE_GAIN_VAL1;
    chk("reset ctl", 32'(ctl_exp), 32'(afe_ctl));
  endtask : check_reset

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {hsel, hwrite, cmp0_raw, cmp1_raw, opamp0_out} = '0;
    {haddr, hwdata, htrans, hsize} = '0;
    {bad_count, cmp_count, cyc_count} = '0;
    rst_n = 1'b0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    check_reset();
    // Ordinary cases
    foreach (rows[i])
    begin
      bus(rows[i].addr, 1'b1, rows[i].wdata);
      bus(rows[i].addr, 1'b0, 32'h0);
      chk("row read", rows[i].rexp, rd);
    end
    repeat (2) @(posedge core_clk);
    chk("dac1 code", 32'h0000_00A5, 32'(afe_ctl.dac1_code));
    chk("opamp enable", 32'h1, 32'(afe_ctl.opa0_en));
    chk("gain select", 32'h7, 32'(afe_ctl.gain_sel));
    // Every gain code, including the two odd ones
    for (int i = 0; i < 8; i++)
    begin
      bus(AFE_OFS_GAIN_POL, 1'b1, 32'(i));
      repeat (2) @(posedge core_clk);
      chk("gain ratio", 32'(gtab[i]), 32'(afe_ctl.gain_ratio));
      chk("gain select", 32'(i), 32'(afe_ctl.gain_sel));
    end
    for (int i = 0; i < 4; i++)
    begin
      bus(AFE_OFS_OPAMP0_CTL, 1'b1, 32'(i));
      repeat (2) @(posedge core_clk);
      chk("bandwidth", 32'(bwtab[i]), 32'(afe_ctl.opa0_bw));
    end
    // Polarity against raw level, both comparators in opposite states
    for (int i = 0; i < 4; i++)
    begin
      cmp0_raw <= i[0];
      cmp1_raw <= ~i[0];
      bus(AFE_OFS_GAIN_POL, 1'b1, {24'h0, i[1], ~i[1], 6'h0});
      repeat (5) @(posedge core_clk);
      chk("cmp0 result", 32'(i[0] ^ i[1]), 32'(cmp0_result));
      chk("cmp1 result", 32'(i[0] ^ i[1]), 32'(cmp1_result));
      bus(AFE_OFS_OPAMP0_CAL, 1'b0, 32'h0);
      chk("result bits", {24'h0, {2{i[0] ^ i[1]}}, 6'h0}, rd);
    end
    // Opamp status only visible while calibrating
    opamp0_out <= 1'b1;
    bus(AFE_OFS_OPAMP0_CAL, 1'b1, 32'hFFFF_FF01);
    repeat (4) @(posedge core_clk);
    chk("cal mode", 32'h1, 32'(afe_ctl.opa0_cal));
    bus(AFE_OFS_OPAMP0_CTL, 1'b1, 32'h0000_0023);
    bus(AFE_OFS_OPAMP0_CTL, 1'b0, 32'h0);
    chk("status cal hi", 32'h0000_0023, rd);
    opamp0_out <= 1'b0;
    repeat (4) @(posedge core_clk);
    bus(AFE_OFS_OPAMP0_CTL, 1'b0, 32'h0);
    chk("status cal lo", 32'h0000_0003, rd);
    bus(AFE_OFS_OPAMP0_CAL, 1'b1, 32'h0);
    opamp0_out <= 1'b1;
    repeat (4) @(posedge core_clk);
    bus(AFE_OFS_OPAMP0_CTL, 1'b0, 32'h0);
    chk("status no cal", 32'h0000_0003, rd);
    // Fresh DAC2 code; comparators quiet so result bits read zero after reset
    bus(AFE_OFS_REF_DAC2, 1'b1, 32'h0000_003C);
    repeat (2) @(posedge core_clk);
    chk("dac2 code", 32'h0000_003C, 32'(afe_ctl.dac2_code));
    cmp0_raw <= 1'b0;
    cmp1_raw <= 1'b0;
    // Second reset in mid run with everything written
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    check_reset();
    complete_run();
  end
endmodule : test_afe_regs

//--- src/afe_pkg.sv
package afe_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] AFE_OFS_REF_DAC1   = 8'h00;
  localparam logic [7:0] AFE_OFS_REF_DAC2   = 8'h04;
  localparam logic [7:0] AFE_OFS_GAIN_POL   = 8'h08;
  localparam logic [7:0] AFE_OFS_OPAMP0_CTL = 8'h0C;
  localparam logic [7:0] AFE_OFS_OPAMP0_CAL = 8'h10;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int AFE_POS_CMP0_INV   = 7;
  localparam int AFE_POS_CMP1_INV   = 6;
  localparam int AFE_POS_OPA_EN     = 6;
  localparam int AFE_POS_OPA_STAT   = 5;
  localparam int AFE_POS_CAL_MODE   = 0;
  localparam logic [7:0] AFE_RST_BYTE = 8'h00;

  // ****************************************
  // Gain and bandwidth encodings
  // ****************************************
  localparam logic [2:0] AFE_GAIN_X56 = 3'h6;
  localparam logic [2:0] AFE_GAIN_X1B = 3'h7;
  localparam logic [5:0] AFE_GAIN_VAL56 = 6'h38;
  localparam logic [5:0] AFE_GAIN_VAL1  = 6'h01;

  typedef enum logic [1:0]
  {
    AFE_BW_5K   = 2'b00,
    AFE_BW_40K  = 2'b01,
    AFE_BW_600K = 2'b10,
    AFE_BW_2M   = 2'b11
  } afe_bw_t;

  // Analog control bundle handed to the analog macros
  typedef struct packed
  {
    logic [7:0] dac1_code;
    logic [7:0] dac2_code;
    logic [2:0] gain_sel;
    logic [5:0] gain_ratio;
    logic       opa0_en;
    afe_bw_t    opa0_bw;
    logic       opa0_cal;
  } afe_ctl_t;

  // Captured AHB address phase
  typedef struct packed
  {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
  } afe_aphase_t;

endpackage : afe_pkg

//--- src/afe_regs.sv
`timescale 1ns/1ns
// Summary of operation
// (R01) Second DAC 8-bit code, RW, clears
// (R02) Third DAC 8-bit code, RW, clears
// (R03) Bit7 inverts comparator 0 result
// (R04) Bit6 inverts comparator 1 result
// (R05) Gain field decodes ratios, 110=56, 111=1
// (R06) Opamp status shows output only when calibrating
// (R07) Bandwidth code selects 5k/40k/600k/2M
// (R08) Unused bits read zero, writes ignored
module afe_regs
  import afe_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        cmp0_raw,
  input  wire logic        cmp1_raw,
  input  wire logic        opamp0_out,
  output logic             cmp0_result,
  output logic             cmp1_result,
  output afe_ctl_t         afe_ctl
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] sync_a;
  logic [2:0] sync_b;

  // Analog outputs are asynchronous to core_clk
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end
    else
    begin
      sync_a <= {opamp0_out, cmp1_raw, cmp0_raw};
      sync_b <= sync_a;
    end
  end

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  afe_aphase_t aph;
  logic        take;

  assign take = hsel && hready && htrans[1];

  // Zero wait states: capture address phase, act in data phase
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      aph <= '0;
    end
    else
    begin
      aph.wr   <= take && hwrite;
      aph.rd   <= take && !hwrite;
      aph.addr <= haddr[7:0];
    end
  end

  // Always ready and OKAY; only word access is used by software
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] ref_dac1_code;
  logic [7:0] ref_dac2_code;
  logic       cmp0_invert;
  logic       cmp1_invert;
  logic [2:0] amp_gain_select;
  logic       opamp0_enable;
  afe_bw_t    opamp0_bandwidth;
  logic       opamp0_calibration_mode;
  logic       opamp0_output_status;

  // Only implemented bits are stored; others drop writes
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      ref_dac1_code           <= AFE_RST_BYTE;                // see (R01)
      ref_dac2_code           <= AFE_RST_BYTE;                // see (R02)
      cmp0_invert             <= 1'b0;
      cmp1_invert             <= 1'b0;
      amp_gain_select         <= 3'h0;
      opamp0_enable           <= 1'b0;
      opamp0_bandwidth        <= AFE_BW_5K;
      opamp0_calibration_mode <= 1'b0;
    end
    else if (aph.wr)
    begin
      unique case (aph.addr)
        AFE_OFS_REF_DAC1:   ref_dac1_code <= hwdata[7:0];    // see (R01)
        AFE_OFS_REF_DAC2:   ref_dac2_code <= hwdata[7:0];    // see (R02)
        AFE_OFS_GAIN_POL:
        begin
          cmp0_invert     <= hwdata[AFE_POS_CMP0_INV];        // see (R03)
          cmp1_invert     <= hwdata[AFE_POS_CMP1_INV];        // see (R04)
          amp_gain_select <= hwdata[2:0];                     // see (R05)
        end
        AFE_OFS_OPAMP0_CTL:
        begin
          opamp0_enable    <= hwdata[AFE_POS_OPA_EN];
          opamp0_bandwidth <= afe_bw_t'(hwdata[1:0]);         // see (R07)
        end
        AFE_OFS_OPAMP0_CAL: opamp0_calibration_mode <= hwdata[AFE_POS_CAL_MODE];
        default: ;                                            // see (R08)
      endcase
    end
  end

  // ****************************************
  // Status and polarity
  // ****************************************
  // Status bit is forced low outside calibration mode
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      opamp0_output_status <= 1'b0;
      cmp0_result          <= 1'b0;
      cmp1_result          <= 1'b0;
    end
    else
    begin
      opamp0_output_status <= opamp0_calibration_mode && sync_b[2];  // see (R06)
      cmp0_result          <= sync_b[0] ^ cmp0_invert;               // see (R03)
      cmp1_result          <= sync_b[1] ^ cmp1_invert;               // see (R04)
    end
  end

  // Gain ratio decode for the control output; the assertions check against constants
  function automatic logic [5:0] gain_ratio(input logic [2:0] sel);
    if (sel == AFE_GAIN_X56)
      return AFE_GAIN_VAL56;
    else if (sel == AFE_GAIN_X1B)
      return AFE_GAIN_VAL1;
    else
      return 6'(AFE_GAIN_VAL1 << sel);
  endfunction : gain_ratio

  // Registered bundle to the analog side
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      afe_ctl <= '{gain_ratio: AFE_GAIN_VAL1, opa0_bw: AFE_BW_5K, default: '0};
    end
    else
    begin
      afe_ctl.dac1_code  <= ref_dac1_code;
      afe_ctl.dac2_code  <= ref_dac2_code;
      afe_ctl.gain_sel   <= amp_gain_select;
      afe_ctl.gain_ratio <= gain_ratio(amp_gain_select);      // see (R05)
      afe_ctl.opa0_en    <= opamp0_enable;
      afe_ctl.opa0_bw    <= opamp0_bandwidth;                 // see (R07)
      afe_ctl.opa0_cal   <= opamp0_calibration_mode;
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  logic [31:0] next_rdata;

  // Read result bits hold the polarity-corrected comparator
  always_comb
  begin
    next_rdata = 32'h0000_0000;                               // see (R08)
    if (take && !hwrite)
    begin
      unique case (haddr[7:0])
        AFE_OFS_REF_DAC1:   next_rdata[7:0] = ref_dac1_code;
        AFE_OFS_REF_DAC2:   next_rdata[7:0] = ref_dac2_code;
        AFE_OFS_GAIN_POL:   next_rdata[7:0] = {cmp0_invert, cmp1_invert, 3'h0, amp_gain_select};
        AFE_OFS_OPAMP0_CTL: next_rdata[7:0] = {1'b0, opamp0_enable, opamp0_output_status,
                                               3'h0, opamp0_bandwidth};
        AFE_OFS_OPAMP0_CAL: next_rdata[7:0] = {cmp0_result, cmp1_result, 5'h00,
                                               opamp0_calibration_mode};
        default:            next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Data available in the cycle after the address phase
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      hrdata <= 32'h0000_0000;
    else
      hrdata <= next_rdata;
  end

  // ****************************************
  // Assertions
  // ****************************************
  // Reference DAC codes: stored on write, held otherwise, forwarded a cycle later
  a_dac1_write: assert property (@(posedge core_clk) disable iff (!rst_n) // see (R01)
    aph.wr && aph.addr == AFE_OFS_REF_DAC1 |=> ref_dac1_code == $past(hwdata[7:0]))
    else $error("dac1 code not stored");
  a_dac1_hold: assert property (@(posedge core_clk) disable iff (!rst_n) // see (R01)
    !aph.wr |=> $stable(ref_dac1_code))
    else $error("dac1 code changed without write");
  a_dac1_fwd: assert property (@(posedge core_clk) disable iff (!rst_n) // see (R01)
    ##1 afe_ctl.dac1_code == $past(ref_dac1_code))
    else $error("dac1 code not forwarded");
  a_dac2_write: assert property (@(posedge core_clk) disable iff (!rst_n) // see (R02)
    aph.wr && aph.addr == AFE_OFS_REF_DAC2 |=>
      ##1 afe_ctl.dac2_code == $past(hwdata[7:0], 2))
    else $error("dac2 code not forwarded");

  // Comparator polarity and the readable result bits
  a_cmp0_polarity: assert property (@(posedge core_clk) disable iff (!rst_n) // see (R03)
    ##1 cmp0_result == ($past(sync_b[0]) ^ $past(cmp0_invert)))
    else $error("cmp0 polarity wrong");
  a_cmp1_polarity: assert property (@(posedge core_clk) disable iff (!rst_n) // see (R04)
    ##1 cmp1_result == ($past(sync_b[1]) ^ $past(cmp1_invert)))
    else $error("cmp1 polarity wrong");
  a_cmp_read: assert property (@(posedge core_clk) disable iff (!rst_n) // see (R03) (R04)
    take && !hwrite && haddr[7:0] == AFE_OFS_OPAMP0_CAL |=>
      hrdata[7:6] == $past({cmp0_result, cmp1_result}))
    else $error("result bits not readable");

  // Gain decode, including the two codes outside the power-of-two run
  a_gain_x56: assert property (@(posedge core_clk) disable iff (!rst_n) // see (R05)
    amp_gain_select == AFE_GAIN_X56 |=> afe_ctl.gain_ratio == AFE_GAIN_VAL56)
    else $error("gain 56 decode wrong");
  a_gain_x1b: assert property (@(posedge core_clk) disable iff (!rst_n) // see (R05)
    amp_gain_select == AFE_GAIN_X1B |=> afe_ctl.gain_ratio == AFE_GAIN_VAL1)
    else $error("gain code 7 decode wrong");
  a_gain_onehot: assert property (@(posedge core_clk) disable iff (!rst_n) // see (R05)
    amp_gain_select != AFE_GAIN_X56 |=> $onehot(afe_ctl.gain_ratio))
    else $error("gain ratio not a power of two");

  // Opamp status and bandwidth
  a_opa_status_low: assert property (@(posedge core_clk) disable iff (!rst_n) // see (R06)
    !opamp0_calibration_mode |=> !opamp0_output_status)
    else $error("status not low");
  a_opa_status_follow: assert property (@(posedge core_clk) disable iff (!rst_n) // see (R06)
    opamp0_calibration_mode |=> opamp0_output_status == $past(sync_b[2]))
    else $error("status does not follow opamp");
  a_opa_bw_fwd: assert property (@(posedge core_clk) disable iff (!rst_n) // see (R07)
    aph.wr && aph.addr == AFE_OFS_OPAMP0_CTL |=>
      ##1 afe_ctl.opa0_bw == $past(hwdata[1:0], 2))
    else $error("bandwidth not forwarded");
  a_opa_bw_read: assert property (@(posedge core_clk) disable iff (!rst_n) // see (R07)
    take && !hwrite && haddr[7:0] == AFE_OFS_OPAMP0_CTL |=>
      hrdata[1:0] == $past(opamp0_bandwidth))
    else $error("bandwidth not readable");

  // Read data: gaps read zero, and the bus is quiet outside a read
  a_unused_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // see (R08)
    take && !hwrite |=> hrdata[31:8] == 24'h000000)
    else $error("unused bits nonzero");
  a_gain_gap_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // see (R08)
    take && !hwrite && haddr[7:0] == AFE_OFS_GAIN_POL |=>
      hrdata[5:3] == 3'h0)
    else $error("gain register gap nonzero");
  a_ctl_gap_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // see (R08)
    take && !hwrite && haddr[7:0] == AFE_OFS_OPAMP0_CTL |=>
      hrdata[7] == 1'b0 && hrdata[4:2] == 3'h0)
    else $error("opamp register gap nonzero");
  a_rdata_idle: assert property (@(posedge core_clk) disable iff (!rst_n) // see (R08)
    !(take && !hwrite) |=> hrdata == 32'h0000_0000)
    else $error("read data outside a read");

  // Main scenarios
  c_dac1_wr:  cover property (@(posedge core_clk) aph.wr && aph.addr == AFE_OFS_REF_DAC1);
  c_gain_x56: cover property (@(posedge core_clk) amp_gain_select == AFE_GAIN_X56);
  c_cal_on:   cover property (@(posedge core_clk) opamp0_output_status);
  c_cmp0_inv: cover property (@(posedge core_clk) cmp0_invert && cmp0_result);
  c_gain_x1b: cover property (@(posedge core_clk) amp_gain_select == AFE_GAIN_X1B);

endmodule : afe_regs
